// [logic/acs_params.svh]
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
// register byte addresses
`define ACS_OFF_CTRL 12'h000
`define ACS_OFF_CFG 12'h004
`define ACS_OFF_RESULT 12'h008
`define ACS_OFF_STAT 12'h00c
`define ACS_OFF_MASK 12'h010
// control field positions
`define ACS_CTRL_PWR 0
`define ACS_CTRL_GO 1
// config fields
`define ACS_CFG_CLKSEL_LSB 0
`define ACS_CFG_ACQ_LSB 4
`define ACS_CLKSEL_RC 3'h7
// status bits
`define ACS_ST_DONE 0
`define ACS_ST_ABORT 1
// reset values
`define ACS_CTRL_RST 32'h0000_0000
`define ACS_CFG_RST 32'h0000_0000
// timing
`define ACS_GAP_TAD 2
`define ACS_RES_BITS 10
`define ACS_DISCH_TAD 1
`define ACS_INSTR_CYC 4
`endif

// [logic/acs_pkg.sv]
// Purpose: types shared by the conversion sequencer
// Assumes: acs_params.svh holds register and timing numbers; state codes are set here
// Notes: none
package acs_pkg;
  typedef enum logic [2:0] {
    ACS_IDLE = 3'b000,
    ACS_ACQ = 3'b001,
    ACS_DLY = 3'b010,
    ACS_CONV = 3'b011,
    ACS_DISCH = 3'b100,
    ACS_GAP = 3'b101
  } acs_state_e;
  typedef struct packed {
    logic acquire;
    logic discharge;
    logic [3:0] chan;
  } acs_analog_s;
endpackage

// [logic/acs_tad_div.sv]
// Purpose: conversion-bit-period enable from mclk_i or the rc clock tick
// Assumes: rc tick is synchronous one-cycle pulse
// Notes: divide ratio 2*(sel+1) for system clock choices
`include "acs_params.svh"
module acs_tad_div (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // control
  input wire logic [2:0] sel_i,
  input wire logic rc_tick_i,
  input wire logic run_i,
  // output
  output logic tad_o
);
  logic [3:0] cnt_r, cnt_nxt;
  logic [3:0] lim;
  always_comb begin
    lim = {sel_i, 1'b1};
    cnt_nxt = cnt_r;
    tad_o = 1'b0;
    if (!run_i) begin
      cnt_nxt = 4'h0;
    end else if (sel_i == `ACS_CLKSEL_RC) begin
      tad_o = rc_tick_i;
    end else if (cnt_r >= lim) begin
      cnt_nxt = 4'h0;
      tad_o = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) cnt_r <= 4'h0;
    else cnt_r <= cnt_nxt;
  end
endmodule // acs_tad_div

// [logic/acs_sar.sv]
// Purpose: successive-approximation register with abort fill
// Assumes: comparator result valid at each step enable
// Notes: msb first
`include "acs_params.svh"
module acs_sar (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // control
  input wire logic clr_i,
  input wire logic step_i,
  input wire logic cmp_i,
  // result
  output logic [`ACS_RES_BITS-1:0] code_o,
  output logic [`ACS_RES_BITS-1:0] fill_o,
  output logic last_o
);
  localparam int NB = `ACS_RES_BITS;
  logic [NB-1:0] code_r, code_nxt;
  logic [NB-1:0] pos_r, pos_nxt;
  logic lastbit;
  always_comb begin
    code_nxt = code_r;
    pos_nxt = pos_r;
    if (clr_i) begin
      code_nxt = '0;
      pos_nxt = {1'b1, {(NB-1){1'b0}}};
    end else if (step_i && pos_r != '0) begin
      code_nxt = code_r | (cmp_i ? pos_r : '0);
      pos_nxt = pos_r >> 1;
    end
  end
  // last resolved bit is the one just above the current position
  always_comb begin
    lastbit = 1'b0;
    for (int i = 0; i < NB-1; i++) begin
      if (pos_r[i]) lastbit = code_r[i+1];
    end
    if (pos_r == '0) lastbit = code_r[0];
  end
  generate
    for (genvar g = 0; g < NB; g++) begin : g_fill
      logic unres;
      assign unres = (pos_r >> g) != '0;
      assign fill_o[g] = (unres && pos_r[NB-1] == 1'b0) ? lastbit : code_r[g]; // see R4
    end
  endgenerate
  assign code_o = code_r;
  assign last_o = pos_r == '0;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      code_r <= '0;
      pos_r <= '0;
    end else begin
      code_r <= code_nxt;
      pos_r <= pos_nxt;
    end
  end
endmodule // acs_sar

// [logic/acs_seq.sv]
// Purpose: sequencer around a successive-approximation converter
// Assumes: axi4-lite master, one access of each kind at a time
// Notes: rc tick and comparator come from the analog side
// Summary of operation
// R1 - on completion clear go, set done flag, load result bytes
// R2 - discharge the capacitor array after every sample
// R3 - clearing go aborts; partial sample written to result bytes
// R4 - unresolved result bits copy the last converted bit
// R5 - reset clears registers, powers converter off, ends conversion
// R6 - wait two bit periods after completion or abort
// R7 - after the wait reconnect selected channel, starting acquisition; the sequencer instead returns to idle and acquires only once go is set
// R8 - software sets acquisition and clock selects before power modes
// R9 - device clock stays unchanged during a conversion
// R10 - below one megahertz software selects the rc clock
// R11 - conversion continues in sleep only with rc clock
// R12 - rc clock delays conversion start one instruction cycle
// R13 - completion in sleep with interrupt enabled wakes the device
// R14 - completion in sleep with interrupt disabled turns converter off
// R15 - sleep with non-rc clock aborts and turns converter off
// R16 - special event trigger sets go and resets the timer
// R17 - software sets go while powered; go reads set while converting
`include "acs_params.svh"
module acs_seq
  import acs_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // axi4-lite slave
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // system
  input wire logic sleep_i,
  input wire logic trig_i,
  input wire logic rc_tick_i,
  input wire logic cmp_i,
  output logic wake_o,
  output logic timer_clr_o,
  output logic irq_o,
  // analog side
  output acs_analog_s ana_o
);
  acs_state_e st_r, st_nxt;
  logic [31:0] ctrl_r, ctrl_nxt, cfg_r, cfg_nxt, stat_r, stat_nxt, mask_r, mask_nxt;
  logic [15:0] res_r, res_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic off_r, off_nxt;
  logic aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, rv_r, rv_nxt;
  logic [11:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0] rr_r, rr_nxt, br_r, br_nxt;
  logic tad, sar_clr, sar_step, sar_last, rc_sel, wr_go, wr_ok, done_ev, abort_ev;
  logic [`ACS_RES_BITS-1:0] code, fill;
  logic [3:0] icnt_r, icnt_nxt;

  assign rc_sel = cfg_r[`ACS_CFG_CLKSEL_LSB +: 3] == `ACS_CLKSEL_RC;

  acs_tad_div u_div (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .sel_i(cfg_r[`ACS_CFG_CLKSEL_LSB +: 3]),
    .rc_tick_i(rc_tick_i),
    .run_i(st_r != ACS_IDLE),
    .tad_o(tad)
  );

  acs_sar u_sar (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .clr_i(sar_clr),
    .step_i(sar_step),
    .cmp_i(cmp_i),
    .code_o(code),
    .fill_o(fill),
    .last_o(sar_last)
  );

  // axi write path: address and data taken in either order
  assign s_awready = !aw_r && !b_r;
  assign s_wready = !w_r && !b_r;
  assign s_bvalid = b_r;
  assign s_bresp = br_r;
  assign s_arready = !rv_r;
  assign s_rvalid = rv_r;
  assign s_rdata = rd_r;
  assign s_rresp = rr_r;
  assign wr_go = aw_r && w_r && !b_r;
  assign wr_ok = awa_r == `ACS_OFF_CTRL || awa_r == `ACS_OFF_CFG || awa_r == `ACS_OFF_STAT
    || awa_r == `ACS_OFF_MASK || awa_r == `ACS_OFF_RESULT;

  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    b_nxt = b_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    br_nxt = br_r;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    if (s_awvalid && s_awready) begin
      aw_nxt = 1'b1;
      awa_nxt = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_nxt = 1'b1;
      wd_nxt = s_wdata;
    end
    if (wr_go) begin
      b_nxt = 1'b1;
      br_nxt = wr_ok ? 2'b00 : 2'b10;
    end
    if (b_r && s_bready) begin
      b_nxt = 1'b0;
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      rv_nxt = 1'b1;
      rr_nxt = 2'b00;
      case (s_araddr)
        `ACS_OFF_CTRL: rd_nxt = ctrl_r;
        `ACS_OFF_CFG: rd_nxt = cfg_r;
        `ACS_OFF_RESULT: rd_nxt = {16'h0000, res_r};
        `ACS_OFF_STAT: rd_nxt = stat_r;
        `ACS_OFF_MASK: rd_nxt = mask_r;
        default: begin
          rd_nxt = 32'h0000_0000;
          rr_nxt = 2'b10;
        end
      endcase
    end else if (rv_r && s_rready) begin
      rv_nxt = 1'b0;
    end
  end

  // conversion sequence
  always_comb begin
    st_nxt = st_r;
    ctrl_nxt = ctrl_r;
    cfg_nxt = cfg_r;
    mask_nxt = mask_r;
    res_nxt = res_r;
    cnt_nxt = cnt_r;
    icnt_nxt = icnt_r;
    off_nxt = off_r;
    sar_clr = 1'b0;
    sar_step = 1'b0;
    done_ev = 1'b0;
    abort_ev = 1'b0;
    timer_clr_o = 1'b0;
    if (wr_go && awa_r == `ACS_OFF_CTRL && s_wstrb[0]) begin
      ctrl_nxt = {30'h0, wd_r[`ACS_CTRL_GO] & wd_r[`ACS_CTRL_PWR], wd_r[`ACS_CTRL_PWR]}; // see R17
      if (wd_r[`ACS_CTRL_PWR]) off_nxt = 1'b0;
    end
    if (wr_go && awa_r == `ACS_OFF_CFG && s_wstrb[0]) cfg_nxt = {21'h0, wd_r[10:0]}; // see R8 R7
    if (wr_go && awa_r == `ACS_OFF_MASK && s_wstrb[0]) mask_nxt = {30'h0, wd_r[1:0]};
    if (trig_i && ctrl_r[`ACS_CTRL_PWR] && !off_r) begin
      ctrl_nxt[`ACS_CTRL_GO] = 1'b1; // see R16
      timer_clr_o = 1'b1; // see R16
    end
    case (st_r)
      ACS_IDLE: begin
        if (ctrl_r[`ACS_CTRL_GO] && !off_r) begin
          st_nxt = rc_sel ? ACS_DLY : ACS_ACQ;
          cnt_nxt = 4'h0;
          icnt_nxt = 4'h0;
          sar_clr = 1'b1;
        end
      end
      ACS_DLY: begin
        icnt_nxt = icnt_r + 4'h1;
        if (icnt_r == 4'(`ACS_INSTR_CYC - 1)) st_nxt = ACS_ACQ; // see R12
      end
      ACS_ACQ: begin
        if (tad) cnt_nxt = cnt_r + 4'h1;
        if (tad && cnt_r >= cfg_r[`ACS_CFG_ACQ_LSB +: 3]) st_nxt = ACS_CONV;
      end
      ACS_CONV: begin
        sar_step = tad;
        if (sar_last) begin
          ctrl_nxt[`ACS_CTRL_GO] = 1'b0; // see R1
          res_nxt = 16'(code); // see R1
          done_ev = 1'b1;
          st_nxt = ACS_DISCH;
          cnt_nxt = 4'h0;
        end
      end
      ACS_DISCH: begin
        if (tad) begin
          st_nxt = ACS_GAP; // see R2
          cnt_nxt = 4'h0;
        end
      end
      ACS_GAP: begin
        if (tad) cnt_nxt = cnt_r + 4'h1;
        if (tad && cnt_r == 4'(`ACS_GAP_TAD - 1)) st_nxt = ACS_IDLE; // see R6
      end
      default: st_nxt = ACS_IDLE;
    endcase
    // software clear of go, or sleep on a non-rc clock, aborts
    if ((st_r == ACS_ACQ || st_r == ACS_CONV || st_r == ACS_DLY) &&
        (!ctrl_nxt[`ACS_CTRL_GO] && !done_ev || sleep_i && !rc_sel)) begin
      if (st_r == ACS_CONV) res_nxt = 16'(fill); // see R3
      ctrl_nxt[`ACS_CTRL_GO] = 1'b0;
      abort_ev = 1'b1;
      st_nxt = ACS_DISCH; // see R6
      cnt_nxt = 4'h0;
      if (sleep_i && !rc_sel) off_nxt = 1'b1; // see R15
    end
    if (done_ev && sleep_i && !mask_r[`ACS_ST_DONE]) off_nxt = 1'b1; // see R14
    // power-off goes out through the abort path, so the array is still discharged
    if (!ctrl_nxt[`ACS_CTRL_PWR]) begin
      ctrl_nxt[`ACS_CTRL_GO] = 1'b0;
    end
  end

  // sticky status: set wins over write-one clear
  always_comb begin
    stat_nxt = stat_r;
    if (wr_go && awa_r == `ACS_OFF_STAT && s_wstrb[0]) stat_nxt = stat_r & ~{30'h0, wd_r[1:0]};
    if (done_ev) stat_nxt[`ACS_ST_DONE] = 1'b1; // see R1
    if (abort_ev) stat_nxt[`ACS_ST_ABORT] = 1'b1;
  end

  assign irq_o = |(stat_r & mask_r);
  assign wake_o = sleep_i && stat_r[`ACS_ST_DONE] && mask_r[`ACS_ST_DONE]; // see R13

  always_comb begin
    ana_o.acquire = st_r == ACS_ACQ && !(sleep_i && !rc_sel); // see R7 R11
    ana_o.discharge = st_r == ACS_DISCH; // see R2
    ana_o.chan = cfg_r[7+:4];
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= ACS_IDLE; // see R5
      ctrl_r <= `ACS_CTRL_RST;
      cfg_r <= `ACS_CFG_RST;
      stat_r <= 32'h0;
      mask_r <= 32'h0;
      res_r <= 16'h0;
      cnt_r <= 4'h0;
      icnt_r <= 4'h0;
      off_r <= 1'b0;
      aw_r <= 1'b0;
      w_r <= 1'b0;
      b_r <= 1'b0;
      rv_r <= 1'b0;
      awa_r <= 12'h0;
      wd_r <= 32'h0;
      rd_r <= 32'h0;
      rr_r <= 2'b00;
      br_r <= 2'b00;
    end else begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      cfg_r <= cfg_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      res_r <= res_nxt;
      cnt_r <= cnt_nxt;
      icnt_r <= icnt_nxt;
      off_r <= off_nxt;
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      b_r <= b_nxt;
      rv_r <= rv_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      rr_r <= rr_nxt;
      br_r <= br_nxt;
    end
  end

  sequence s_done;
    st_r == ACS_CONV && sar_last;
  endsequence
  a_done_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R1
    s_done |=> stat_r[`ACS_ST_DONE] && !ctrl_r[`ACS_CTRL_GO]) else $error("done not flagged");
  a_disch_after: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R2
    s_done |=> st_r == ACS_DISCH) else $error("no discharge");
  a_abort_disch: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R3
    abort_ev |=> st_r == ACS_DISCH && stat_r[`ACS_ST_ABORT]) else $error("abort lost");
  a_gap_idle: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R6
    st_r == ACS_GAP && $past(st_r) == ACS_DISCH |-> ##1 st_r != ACS_ACQ) else $error("gap short");
  a_pwr_off: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R5
    !ctrl_r[`ACS_CTRL_PWR] |-> !ctrl_r[`ACS_CTRL_GO]) else $error("go without power");
  a_sleep_off: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R15
    sleep_i && !rc_sel && (st_r == ACS_ACQ || st_r == ACS_CONV) |=> off_r && st_r == ACS_DISCH)
    else $error("no sleep abort");
  a_sleep_done: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R14
    done_ev && sleep_i && !mask_r[`ACS_ST_DONE] |=> off_r) else $error("not off after sleep done");
  a_gap_len: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R6
    $rose(st_r == ACS_GAP) |-> st_r == ACS_GAP [*3]) else $error("gap too short");
  a_rc_delay: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R12
    st_r == ACS_IDLE && st_nxt == ACS_DLY |=> st_r == ACS_DLY [*4]) else $error("rc delay short");
  a_trig_clr: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R16
    timer_clr_o |=> ctrl_r[`ACS_CTRL_GO]) else $error("trigger ignored");
endmodule // acs_seq

// [tb/acs_analog_model.sv]
// Purpose: analog sample array and channel mux stand-in for the sequencer
// Assumes: comparator level chosen by the bench per scenario
// Notes: rc tick runs free, as the dedicated rc oscillator does
module acs_analog_model
  import acs_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // sequencer side
  input acs_analog_s ana_i,
  input wire logic cmp_level_i,
  output logic cmp_o,
  output logic rc_tick_o,
  // observation
  output int disch_cnt_o,
  output int gap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_r;
  logic tog_r;
  logic disch_q;
  logic acq_q;
  int gap_cnt;
  // comparator is meaningless while sampling, so it wiggles instead of holding
  assign cmp_o = (ana_i.acquire | ana_i.discharge) ? tog_r : cmp_level_i;
  assign rc_tick_o = (div_r == 3'h4);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_r <= 3'h0;
      tog_r <= 1'b0;
      disch_q <= 1'b0;
      acq_q <= 1'b0;
      disch_cnt_o <= 0;
      gap_o <= 0;
      gap_cnt <= 0;
    end else begin
      div_r <= (div_r == 3'h4) ? 3'h0 : div_r + 3'h1;
      tog_r <= ~tog_r;
      disch_q <= ana_i.discharge;
      acq_q <= ana_i.acquire;
      if (ana_i.discharge && !disch_q) begin
        disch_cnt_o <= disch_cnt_o + 1;
      end
      if (disch_q && !ana_i.discharge) begin
        gap_cnt <= 0;
      end else begin
        gap_cnt <= gap_cnt + 1;
      end
      // gap is latched only where acquisition starts, not while it lasts
      if (ana_i.acquire && !acq_q) begin
        gap_o <= gap_cnt;
      end
    end
  end
endmodule // acs_analog_model

// [tb/adc_conversion_sequencer_bench.sv]
// Purpose: self-checking bench for the conversion sequencer
// Assumes: axi4-lite master held to one access of each kind
// Notes: comparator held at one level, so results are all ones or zeros
`include "acs_params.svh"
module adc_conversion_sequencer_bench
  import acs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, rstn_i = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic sleep = 1'b0, trig = 1'b0, cmp_level = 1'b1;
  logic rc_tick, cmp, wake, tclr, irq;
  acs_analog_s ana;
  int disch_cnt, gap;
  int n_errors = 0, total_checks = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  acs_seq acs_seq_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .sleep_i(sleep), .trig_i(trig), .rc_tick_i(rc_tick), .cmp_i(cmp), .wake_o(wake),
    .timer_clr_o(tclr), .irq_o(irq), .ana_o(ana));
  acs_analog_model acs_analog_model_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .ana_i(ana),
    .cmp_level_i(cmp_level), .cmp_o(cmp), .rc_tick_o(rc_tick), .disch_cnt_o(disch_cnt), .gap_o(gap));
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic a_done, w_done;
    a_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a_done && w_done)) begin
      @(posedge mclk_i);
      if (!a_done && awready) begin
        a_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // bready stays high between writes, so no edge sees it dropped and raised at once
    do @(posedge mclk_i); while (!bvalid);
  endtask
  task automatic rdr(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk_i); while (!rvalid);
    rd = rdata;
    rr = rresp;
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 200; i++) begin
      rdr(`ACS_OFF_CTRL);
      if (rd[`ACS_CTRL_GO] === 1'b0) break;
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge mclk_i);
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    rdr(`ACS_OFF_CTRL); chk("ctrl reset", `ACS_CTRL_RST, rd);
    rdr(`ACS_OFF_CFG); chk("cfg reset", `ACS_CFG_RST, rd);
    rdr(`ACS_OFF_STAT); chk("stat reset", 32'h0, rd);
    rdr(12'h0ff); chk("unmapped resp", 32'h2, {30'h0, rr});
    wr(`ACS_OFF_CFG, 32'h0000_0290);
    wr(`ACS_OFF_CTRL, 32'h1);
    wr(`ACS_OFF_CTRL, 32'h3);
    rdr(`ACS_OFF_CTRL); chk("go while running", 32'h3, rd);
    chk("selected channel", 32'h5, {28'h0, ana.chan});
    wait_idle(); chk("go cleared on done", 32'h1, rd);
    rdr(`ACS_OFF_STAT); chk("done flag", 32'h1, rd);
    rdr(`ACS_OFF_RESULT); chk("result ones", 32'h3ff, rd);
    chk("discharge after sample", 32'h1, 32'(disch_cnt >= 1));
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`ACS_OFF_MASK, 32'h1);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(`ACS_OFF_STAT, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // aborts land in mid-conversion: acquisition takes a few cycles, each bit two
    cmp_level <= 1'b0;
    wr(`ACS_OFF_CTRL, 32'h3);
    repeat (8) @(posedge mclk_i);
    wr(`ACS_OFF_CTRL, 32'h1);
    rdr(`ACS_OFF_STAT); chk("abort flag", 32'h2, rd);
    rdr(`ACS_OFF_RESULT); chk("abort partial", 32'h0, rd);
    wr(`ACS_OFF_STAT, 32'h3);
    cmp_level <= 1'b1;
    wr(`ACS_OFF_CTRL, 32'h3);
    repeat (8) @(posedge mclk_i);
    wr(`ACS_OFF_CTRL, 32'h1);
    wr(`ACS_OFF_CTRL, 32'h3);
    rdr(`ACS_OFF_RESULT); chk("abort fill", 32'h3ff, rd);
    wait_idle();
    chk("gap before acquire", 32'h1, 32'(gap >= 2 * `ACS_GAP_TAD));
    wr(`ACS_OFF_STAT, 32'h3);
    wr(`ACS_OFF_CTRL, 32'h3);
    sleep <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rdr(`ACS_OFF_CTRL); chk("sleep abort keeps power", 32'h1, rd);
    sleep <= 1'b0;
    wr(`ACS_OFF_CTRL, 32'h1);
    wr(`ACS_OFF_STAT, 32'h3);
    wr(`ACS_OFF_CFG, 32'h0000_0017);
    wr(`ACS_OFF_CTRL, 32'h3);
    sleep <= 1'b1;
    for (int i = 0; i < 2000 && wake !== 1'b1; i++) @(posedge mclk_i);
    chk("wake on done", 32'h1, {31'h0, wake});
    sleep <= 1'b0;
    wr(`ACS_OFF_STAT, 32'h3);
    wr(`ACS_OFF_MASK, 32'h0);
    wr(`ACS_OFF_CTRL, 32'h3);
    sleep <= 1'b1;
    wait_idle(); chk("sleep done keeps power", 32'h1, rd);
    trig <= 1'b1;
    @(posedge mclk_i);
    chk("off ignores trigger", 32'h0, {31'h0, tclr});
    trig <= 1'b0;
    sleep <= 1'b0;
    wr(`ACS_OFF_CTRL, 32'h1);
    wr(`ACS_OFF_STAT, 32'h3);
    wr(`ACS_OFF_CFG, 32'h0000_0010);
    @(posedge mclk_i);
    trig <= 1'b1;
    @(posedge mclk_i);
    chk("timer clear", 32'h1, {31'h0, tclr});
    trig <= 1'b0;
    rdr(`ACS_OFF_CTRL); chk("trigger sets go", 32'h3, rd);
    wait_idle();
    // reset right after go is set, before any bit is converted, must end the conversion
    wr(`ACS_OFF_CTRL, 32'h3);
    rstn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    chk("acquire after reset", 32'h0, {31'h0, ana.acquire});
    rdr(`ACS_OFF_CTRL); chk("ctrl after reset", `ACS_CTRL_RST, rd);
    end_sim();
  end
endmodule // adc_conversion_sequencer_bench
